// *** core/gpb_params.svh ***
// Purpose: Register offsets, field positions and reset values of the GPIO ports block
// Assumes: Included by its bare name from the package and the port module
// Notes:   Definitions only; guarded against double inclusion
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define GPB_OFS_B_LATCH    8'h06
`define GPB_OFS_C_LATCH    8'h07
`define GPB_OFS_D_LATCH    8'h08
`define GPB_OFS_OPTIONS    8'h81
`define GPB_OFS_B_DIR      8'h86
`define GPB_OFS_C_DIR      8'h87
`define GPB_OFS_D_DIR      8'h88
`define GPB_OFS_CTRL_E     8'h89
`define GPB_OFS_IRQ_STAT   8'h8a
`define GPB_OFS_IRQ_MASK   8'h8b

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPB_RST_DIR        8'hff
`define GPB_RST_OPTIONS    8'hff
`define GPB_RST_DIR_E      3'h7
`define GPB_RST_CTRL_E     8'h07
`define GPB_RST_IRQ        3'h0

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define GPB_BIT_PULLUP_N   7
`define GPB_BIT_EDGE_SEL   6
`define GPB_BIT_IBF        7
`define GPB_BIT_OBF        6
`define GPB_BIT_INPUT_BUFFER_OVERFLOW       5
`define GPB_BIT_MODE       4
`define GPB_CHANGE_PINS    8'hf0
`define GPB_IRQ_CHANGE     0
`define GPB_IRQ_EXT        1
`define GPB_IRQ_PSP        2

`endif

// *** core/gpb_pkg.sv ***
// Purpose: Shared types of the GPIO ports block
// Assumes: gpb_params.svh holds all numeric constants
// Notes:   Pin bundles and strobe groups travel as packed structs
`include "gpb_params.svh"

package gpb_pkg;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    // Output side of one 8-bit port
    typedef struct packed {
        logic [7:0] drive;   // Value driven while enabled
        logic [7:0] oe;      // High while the pin is driven
    } gpb_pin_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;    // Register offset
        logic [7:0] wdata;   // Write data
        logic       wr;      // One-cycle write strobe
        logic       rd;      // One-cycle read strobe
    } gpb_bus_s;

    // Slave port strobes from the port E control logic, all active low
    typedef struct packed {
        logic rdN;
        logic wrN;
        logic csN;
    } gpb_psp_s;

    // Slave port access tracking
    typedef enum logic [1:0] {
        PSP_IDLE,
        PSP_WRITE,
        PSP_READ
    } gpb_psp_e;

endpackage

// *** core/gpb_ports.sv ***
// Purpose: Ports B, C and D with direction control, change and edge interrupts,
//          pull-up control and the parallel slave data port on port D
// Assumes: Pin inputs are synchronous to mclk; rst_n is power-on/brown-out
// Notes:   Data latches carry no reset so they keep their value on other resets
`include "gpb_params.svh"

module gpb_ports (
    input  wire logic             mclk,            // Core clock, 100 MHz
    input  wire logic             rst_n,           // Power-on / brown-out reset
    input  wire logic             otherRst,        // Synchronous reset of other sources
    input  wire gpb_pkg::gpb_bus_s bus,            // Register port request
    output      logic [7:0]       rdata,           // Read data, cycle after strobe
    output      logic             irq,             // Level interrupt
    input  wire logic [7:0]       pinBIn,          // Port B pin levels
    output      gpb_pkg::gpb_pin_s pinB,           // Port B drive and enable
    output      logic [7:0]       pullupB,         // Port B weak pull-up on
    output      logic             schmittB0,       // Pin B0 Schmitt select
    output      logic [1:0]       schmittB76,      // Pins B7/B6 Schmitt select
    input  wire logic             progMode,        // Serial programming mode
    input  wire logic             progDataOut,     // Programming data to drive
    input  wire logic             progDataOe,      // Programming data drive enable
    output      logic             progClock,       // Synchronised programming clock
    output      logic             progData,        // Synchronised programming data
    input  wire logic [7:0]       pinCIn,          // Port C pin levels
    output      gpb_pkg::gpb_pin_s pinC,           // Port C drive and enable
    input  wire logic [7:0]       pinDIn,          // Port D pin levels
    output      gpb_pkg::gpb_pin_s pinD,           // Port D drive and enable
    output      logic             ttlD,            // Port D TTL threshold select
    input  wire gpb_pkg::gpb_psp_s parallel_slave_port,            // Slave port strobes
    output      logic             slavePortMode,   // Slave port mode to port E logic
    output      logic [2:0]       dirE             // Port E directions
);
    import gpb_pkg::*;

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    // True when a write strobe targets the given offset
    function automatic logic wrHit(input gpb_bus_s b, input logic [7:0] ofs);
        wrHit = b.wr && (b.addr == ofs);
    endfunction

    // True when a read strobe targets the given offset
    function automatic logic rdHit(input gpb_bus_s b, input logic [7:0] ofs);
        rdHit = b.rd && (b.addr == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0] latchB_r;       // Port B output latch
    logic [7:0] latchC_r;       // Port C output latch
    logic [7:0] latchD_r;       // Port D output latch
    logic [7:0] dirB_r;         // Port B direction, 1 = input
    logic [7:0] dirC_r;         // Port C direction
    logic [7:0] dirD_r;         // Port D direction
    logic [7:0] options_r;      // Pull-up and edge options
    logic [2:0] dirE_r;         // Port E directions
    logic       mode_r;         // Slave port mode
    logic       ibf_r;          // Input buffer full
    logic       obf_r;          // Output buffer full
    logic       input_buffer_overflow_r;         // Input buffer overflow
    logic [7:0] inBuf_r;        // Word written by external master
    logic [7:0] stage_r;        // Data sampled during external write
    logic [7:0] syncB1_r;       // First synchroniser stage
    logic [7:0] syncB2_r;       // Second synchroniser stage
    logic [7:0] oldB_r;         // Port B value at last access
    logic       prevB0_r;       // Pin B0 one cycle back
    logic [2:0] irqStat_r;      // Sticky event bits
    logic [2:0] irqMask_r;      // Event enables
    gpb_psp_e   pspState_r;     // Slave port access state
    gpb_psp_e   pspState_nxt;

    logic       pullupEnN;      // Global pull-up enable, active low
    logic       edgeRise;       // External interrupt on rising edge
    logic       mismatch;       // Any input pin B7..B4 changed
    logic       extEdge;        // Selected edge on pin B0
    logic       pspActive;      // External strobe chip-selected
    logic       pspWrDone;      // External write finished, one cycle
    logic       pspRdDone;      // External read finished, one cycle
    logic       pspReadNow;     // External read in progress
    logic [7:0] ctrlE;          // Control E as read
    logic [2:0] irqEvents;      // Events of this cycle
    logic       cpuRdD;         // Core reads port D
    logic       cpuWrD;         // Core writes port D

    assign pullupEnN = options_r[`GPB_BIT_PULLUP_N];
    assign edgeRise  = options_r[`GPB_BIT_EDGE_SEL];
    assign cpuRdD    = rdHit(bus, `GPB_OFS_D_LATCH);
    assign cpuWrD    = wrHit(bus, `GPB_OFS_D_LATCH);
    // Bit 3 reads as zero
    assign ctrlE = {ibf_r, obf_r, input_buffer_overflow_r, mode_r, 1'b0, dirE_r};

    // ------------------------------------------------------------------------
    // Data latches
    // ------------------------------------------------------------------------
    // No reset here: unknown after power-up, untouched by any other reset
    // latches keep contents
    always_ff @(posedge mclk) begin
        if (wrHit(bus, `GPB_OFS_B_LATCH)) begin
            latchB_r <= bus.wdata;
        end
        if (wrHit(bus, `GPB_OFS_C_LATCH)) begin
            latchC_r <= bus.wdata;
        end
        if (cpuWrD) begin
            latchD_r <= bus.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Direction and option registers
    // ------------------------------------------------------------------------
    // directions reset inputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dirB_r    <= `GPB_RST_DIR;
            dirC_r    <= `GPB_RST_DIR;
            dirD_r    <= `GPB_RST_DIR;
            options_r <= `GPB_RST_OPTIONS;
        end else if (otherRst) begin
            dirB_r    <= `GPB_RST_DIR;
            dirC_r    <= `GPB_RST_DIR;
            dirD_r    <= `GPB_RST_DIR;
            options_r <= `GPB_RST_OPTIONS;
        end else begin
            if (wrHit(bus, `GPB_OFS_B_DIR)) begin
                dirB_r <= bus.wdata;
            end
            if (wrHit(bus, `GPB_OFS_C_DIR)) begin
                dirC_r <= bus.wdata;
            end
            if (wrHit(bus, `GPB_OFS_D_DIR)) begin
                dirD_r <= bus.wdata;
            end
            if (wrHit(bus, `GPB_OFS_OPTIONS)) begin
                options_r <= bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control E: mode, directions and buffer flags
    // ------------------------------------------------------------------------
    // Flags set by the slave port win over a core clear in the same cycle
    // control E reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dirE_r <= `GPB_RST_DIR_E;
            mode_r <= 1'b0;
            ibf_r  <= 1'b0;
            obf_r  <= 1'b0;
            input_buffer_overflow_r <= 1'b0;
        end else if (otherRst) begin
            dirE_r <= `GPB_RST_DIR_E;
            mode_r <= 1'b0;
            ibf_r  <= 1'b0;
            obf_r  <= 1'b0;
            input_buffer_overflow_r <= 1'b0;
        end else begin
            if (wrHit(bus, `GPB_OFS_CTRL_E)) begin
                dirE_r <= bus.wdata[2:0];
                mode_r <= bus.wdata[`GPB_BIT_MODE];
            end
            // Input buffer: set on external write, cleared by core read
            if (pspWrDone) begin
                ibf_r <= 1'b1;
            end else if (cpuRdD && mode_r) begin
                ibf_r <= 1'b0;
            end
            // Output buffer: set by core write, cleared by external read
            if (cpuWrD && mode_r) begin
                obf_r <= 1'b1;
            end else if (pspRdDone) begin
                obf_r <= 1'b0;
            end
            // Overflow is cleared only by software
            if (pspWrDone && ibf_r) begin
                input_buffer_overflow_r <= 1'b1;
            end else if (wrHit(bus, `GPB_OFS_CTRL_E)) begin
                input_buffer_overflow_r <= bus.wdata[`GPB_BIT_INPUT_BUFFER_OVERFLOW];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Slave port access tracking
    // ------------------------------------------------------------------------
    assign pspActive  = mode_r && !parallel_slave_port.csN;
    assign pspReadNow = pspActive && !parallel_slave_port.rdN;

    // Next state of the access tracker
    always_comb begin
        pspState_nxt = pspState_r;
        case (pspState_r)
            PSP_IDLE: begin
                if (pspActive && !parallel_slave_port.wrN) begin
                    pspState_nxt = PSP_WRITE;
                end else if (pspReadNow) begin
                    pspState_nxt = PSP_READ;
                end
            end
            PSP_WRITE: begin
                if (!(pspActive && !parallel_slave_port.wrN)) begin
                    pspState_nxt = PSP_IDLE;
                end
            end
            PSP_READ: begin
                if (!pspReadNow) begin
                    pspState_nxt = PSP_IDLE;
                end
            end
            default: begin
                pspState_nxt = PSP_IDLE;
            end
        endcase
    end

    // Accesses complete when their strobe or select goes away
    assign pspWrDone = (pspState_r == PSP_WRITE) && (pspState_nxt == PSP_IDLE);
    assign pspRdDone = (pspState_r == PSP_READ) && (pspState_nxt == PSP_IDLE);

    // Tracker register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pspState_r <= PSP_IDLE;
        end else begin
            pspState_r <= pspState_nxt;
        end
    end

    // Sample the bus while the write strobe stands; load the buffer at its end
    // pin n is data bit n
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= 8'h00;
            inBuf_r <= 8'h00;
        end else begin
            if (pspActive && !parallel_slave_port.wrN) begin
                stage_r <= pinDIn;
            end
            if (pspWrDone) begin
                inBuf_r <= stage_r;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Port B synchroniser, change and edge detection
    // ------------------------------------------------------------------------
    // First stage feeds only the second stage
    // two-stage synchroniser
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncB1_r <= 8'h00;
            syncB2_r <= 8'h00;
            prevB0_r <= 1'b0;
        end else begin
            syncB1_r <= pinBIn;
            syncB2_r <= syncB1_r;
            prevB0_r <= syncB2_r[0];
        end
    end

    // Reference value is taken on every core read or write of port B
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oldB_r <= 8'h00;
        end else if (rdHit(bus, `GPB_OFS_B_LATCH) || wrHit(bus, `GPB_OFS_B_LATCH)) begin
            oldB_r <= syncB2_r;
        end
    end

    assign mismatch = |((syncB2_r ^ oldB_r) & dirB_r & `GPB_CHANGE_PINS);
    assign extEdge  = edgeRise ? (syncB2_r[0] && !prevB0_r) : (!syncB2_r[0] && prevB0_r);

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    always_comb begin
        irqEvents                  = 3'h0;
        irqEvents[`GPB_IRQ_CHANGE] = mismatch;
        irqEvents[`GPB_IRQ_EXT]    = extEdge;
        irqEvents[`GPB_IRQ_PSP]    = pspWrDone;
    end

    // Read clears; an event in the same cycle keeps its bit set.
    // A standing mismatch keeps re-setting the change bit until port B is read or written.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_r <= `GPB_RST_IRQ;
            irqMask_r <= `GPB_RST_IRQ;
        end else if (otherRst) begin
            irqStat_r <= `GPB_RST_IRQ;
            irqMask_r <= `GPB_RST_IRQ;
        end else begin
            if (rdHit(bus, `GPB_OFS_IRQ_STAT)) begin
                irqStat_r <= irqEvents;
            end else begin
                irqStat_r <= irqStat_r | irqEvents;
            end
            if (wrHit(bus, `GPB_OFS_IRQ_MASK)) begin
                irqMask_r <= bus.wdata[2:0];
            end
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Answer stands one cycle only; unmapped offsets read zero
    // port reads return pin levels, except port D in slave mode, which returns the input buffer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                `GPB_OFS_B_LATCH:  rdata <= syncB2_r;
                `GPB_OFS_C_LATCH:  rdata <= pinCIn;
                `GPB_OFS_D_LATCH:  rdata <= mode_r ? inBuf_r : pinDIn;
                `GPB_OFS_OPTIONS:  rdata <= options_r;
                `GPB_OFS_B_DIR:    rdata <= dirB_r;
                `GPB_OFS_C_DIR:    rdata <= dirC_r;
                `GPB_OFS_D_DIR:    rdata <= dirD_r;
                `GPB_OFS_CTRL_E:   rdata <= ctrlE;
                `GPB_OFS_IRQ_STAT: rdata <= {5'h00, irqStat_r};
                `GPB_OFS_IRQ_MASK: rdata <= {5'h00, irqMask_r};
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers and buffer selects
    // ------------------------------------------------------------------------
    // Programming data overrides pin B7 only while programming logic drives it
    // programming pins
    always_comb begin
        pinB.drive = latchB_r;
        pinB.oe    = ~dirB_r;
        if (progMode && progDataOe) begin
            pinB.drive[7] = progDataOut;
            pinB.oe[7]    = 1'b1;
        end
    end
    assign progClock  = syncB2_r[6];
    assign progData   = syncB2_r[7];
    assign schmittB76 = {progMode, progMode};
    // Pin B0 Schmitt select only while the external interrupt is enabled
    assign schmittB0  = irqMask_r[`GPB_IRQ_EXT];

    assign pullupB = pullupEnN ? 8'h00 : dirB_r;

    assign pinC.drive = latchC_r;
    assign pinC.oe    = ~dirC_r;

    // slave mode drives only during reads
    assign pinD.drive = latchD_r;
    assign pinD.oe    = mode_r ? (pspReadNow ? 8'hff : 8'h00) : ~dirD_r;

    assign ttlD          = mode_r;
    assign slavePortMode = mode_r;
    assign dirE          = dirE_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence sPspWrite;
        pspActive && !parallel_slave_port.wrN;
    endsequence

    sequence sPspWriteEnd;
        sPspWrite ##1 !(pspActive && !parallel_slave_port.wrN);
    endsequence

    a_c_dir_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrHit(bus, `GPB_OFS_C_DIR) && !otherRst |=> pinC.oe == ~$past(bus.wdata))
        else $error("port C enable does not follow direction write");
    a_dir_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        otherRst |=> (dirB_r & dirC_r & dirD_r) == 8'hff)
        else $error("directions not all inputs after reset");
    a_ctrl_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        otherRst |=> ctrlE == `GPB_RST_CTRL_E)
        else $error("control E wrong after reset");
    a_latch_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        otherRst && !wrHit(bus, `GPB_OFS_C_LATCH) |=> latchC_r == $past(latchC_r))
        else $error("latch changed by other reset");
    a_psp_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_r && parallel_slave_port.rdN |-> pinD.oe == 8'h00)
        else $error("port D driven in slave mode without read");
    a_psp_capture: assert property (@(posedge mclk) disable iff (!rst_n)
        sPspWriteEnd |=> inBuf_r == $past(pinDIn, 2) && ibf_r)
        else $error("slave write word not captured");
    a_overflow_set: assert property (@(posedge mclk) disable iff (!rst_n)
        ibf_r && pspWrDone && !otherRst |=> input_buffer_overflow_r)
        else $error("overflow not flagged");
    a_ttl_select: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(mode_r) |-> ttlD ##1 ttlD || $fell(mode_r))
        else $error("threshold select not following mode");
    a_change_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        mismatch && !otherRst |=> irqStat_r[`GPB_IRQ_CHANGE])
        else $error("change flag not set on mismatch");
    a_pullup_out: assert property (@(posedge mclk) disable iff (!rst_n)
        wrHit(bus, `GPB_OFS_OPTIONS) && !bus.wdata[7] && !otherRst |=> pullupB == dirB_r)
        else $error("pull-up not gated by direction");
    a_sync_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        ##2 progClock == $past(pinBIn[6], 2))
        else $error("synchroniser depth wrong");

endmodule

// *** verif/gpb_far_side.sv ***
// Purpose: Outside world of the ports: pin drivers and the slave bus master
// Assumes: Outside drivers always drive a pin the block leaves free
// Notes:   Slave data is not held once the strobes are released
module gpb_far_side (
    input  wire logic              mclk,    // Core clock
    input  wire gpb_pkg::gpb_pin_s pinB,    // Port B drive
    input  wire gpb_pkg::gpb_pin_s pinC,    // Port C drive
    input  wire gpb_pkg::gpb_pin_s pinD,    // Port D drive
    output      logic [7:0]        pinBIn,  // Port B level
    output      logic [7:0]        pinCIn,  // Port C level
    output      logic [7:0]        pinDIn,  // Port D level
    output      gpb_pkg::gpb_psp_s parallel_slave_port      // Slave strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpb_pkg::*;
    logic [7:0] extB = 8'h00;  // Outside level, port B
    logic [7:0] extC = 8'hc3;  // Outside level, port C
    logic [7:0] extD = 8'h99;  // Outside level, port D
    initial parallel_slave_port = 3'b111;      // Not selected
    assign pinBIn = (pinB.oe & pinB.drive) | (~pinB.oe & extB);
    assign pinCIn = (pinC.oe & pinC.drive) | (~pinC.oe & extC);
    assign pinDIn = (pinD.oe & pinD.drive) | (~pinD.oe & extD);
    // One slave write; data flips once released
    task automatic slave_write(input logic [7:0] d);
        @(posedge mclk);
        parallel_slave_port <= 3'b100;
        extD <= d;
        @(posedge mclk);
        parallel_slave_port <= 3'b111;
        extD <= ~d;
        repeat (2) @(posedge mclk);
    endtask
    // One slave read; word is taken while the block drives it
    task automatic slave_read(output logic [7:0] d);
        @(posedge mclk);
        parallel_slave_port <= 3'b010;
        @(negedge mclk);
        d = pinDIn;
        @(posedge mclk);
        parallel_slave_port <= 3'b111;
        repeat (2) @(posedge mclk);
    endtask
endmodule

// *** verif/tb.sv ***
// Purpose: Register level tests of the GPIO ports block
// Assumes: One clock; bus strobes one cycle long
// Notes:   Programming data drive is exercised once, then released
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpb_pkg::*;
    logic mclk = 1'b0, rst_n, otherRst, irq, schmittB0, progMode, progClock, ttlD, slavePortMode;
    logic progDataOut, progDataOe, progData;
    logic [7:0] rdata, pullupB, pinBIn, pinCIn, pinDIn, v;
    logic [1:0] schmittB76;
    logic [2:0] dirE;
    gpb_bus_s bus;
    gpb_pin_s pinB, pinC, pinD;
    gpb_psp_s parallel_slave_port;
    int bad_count = 0;
    int cmp_count = 0;
    // Offset and reset value pairs
    logic [15:0] rstTab [5] = '{16'h86ff, 16'h87ff, 16'h88ff, 16'h8907, 16'h81ff};
    always #5 mclk = ~mclk;
    gpb_ports i_dut (.mclk(mclk), .rst_n(rst_n), .otherRst(otherRst), .bus(bus),
        .rdata(rdata), .irq(irq), .pinBIn(pinBIn), .pinB(pinB), .pullupB(pullupB),
        .schmittB0(schmittB0), .schmittB76(schmittB76), .progMode(progMode),
        .progDataOut(progDataOut), .progDataOe(progDataOe), .progClock(progClock),
        .progData(progData), .pinCIn(pinCIn), .pinC(pinC), .pinDIn(pinDIn), .pinD(pinD),
        .ttlD(ttlD), .parallel_slave_port(parallel_slave_port), .slavePortMode(slavePortMode), .dirE(dirE));
    gpb_far_side i_far (.mclk(mclk), .pinB(pinB), .pinC(pinC), .pinD(pinD),
        .pinBIn(pinBIn), .pinCIn(pinCIn), .pinDIn(pinDIn), .parallel_slave_port(parallel_slave_port));
    // One bus cycle, k = {write, read}; read data lands in v
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] k);
        @(posedge mclk);
        bus <= {a, d, k};
        @(posedge mclk);
        bus <= '0;
        @(negedge mclk);
        v = rdata;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        otherRst = 1'b0;
        bus = '0;
        progMode = 1'b0;
        progDataOut = 1'b0;
        progDataOe = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rstTab[i]) begin
            acc(rstTab[i][15:8], 8'h00, 2'b01);
            chk(v, rstTab[i][7:0]);
        end
        acc(8'h87, 8'h0f, 2'b10);
        acc(8'h07, 8'ha5, 2'b10);
        acc(8'h07, 8'h00, 2'b01);
        chk(v, 8'ha3);
        chk(pinC.oe, 8'hf0);
        // Latch survives the other reset, direction does not
        acc(8'h08, 8'h3c, 2'b10);
        acc(8'h88, 8'h00, 2'b10);
        @(posedge mclk) otherRst <= 1'b1;
        @(posedge mclk) otherRst <= 1'b0;
        acc(8'h88, 8'h00, 2'b01);
        chk(v, 8'hff);
        chk(pinD.drive, 8'h3c);
        // Change on an upper input pin
        acc(8'h06, 8'h00, 2'b01);
        acc(8'h8b, 8'h01, 2'b10);
        @(posedge mclk) i_far.extB <= 8'h20;
        repeat (5) @(negedge mclk);
        chk(irq, 1'b1);
        acc(8'h8a, 8'h00, 2'b01);
        chk(v, 8'h01);
        acc(8'h06, 8'h00, 2'b01);
        chk(v, 8'h20);
        acc(8'h8a, 8'h00, 2'b01);
        chk(irq, 1'b0);
        acc(8'h81, 8'h7f, 2'b10);
        chk(pullupB, 8'hff);
        acc(8'h06, 8'h00, 2'b10);
        acc(8'h86, 8'h0f, 2'b10);
        chk(pullupB, 8'h0f);
        chk(pinB.oe, 8'hf0);
        // Rising edge on pin 0; upper pins now outputs, so no change flag
        acc(8'h8b, 8'h02, 2'b10);
        chk(schmittB0, 1'b1);
        @(posedge mclk) i_far.extB <= 8'h21;
        repeat (5) @(negedge mclk);
        chk(irq, 1'b1);
        acc(8'h8a, 8'h00, 2'b01);
        chk(v, 8'h02);
        acc(8'h86, 8'hff, 2'b10);
        @(posedge mclk) progMode <= 1'b1;
        i_far.extB <= 8'h61;
        repeat (4) @(negedge mclk);
        chk(schmittB76, 2'b11);
        chk(progClock, 1'b1);
        // Programming logic drives the data pin
        @(posedge mclk) progDataOe <= 1'b1;
        progDataOut <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(pinB.oe, 8'h80);
        chk(progData, 1'b1);
        @(posedge mclk) progDataOe <= 1'b0;
        // Slave port write from the outside bus
        acc(8'h89, 8'h17, 2'b10);
        chk(ttlD, 1'b1);
        chk(slavePortMode, 1'b1);
        i_far.slave_write(8'h5a);
        acc(8'h89, 8'h00, 2'b01);
        chk(v, 8'h97);
        acc(8'h08, 8'h00, 2'b01);
        chk(v, 8'h5a);
        acc(8'h89, 8'h00, 2'b01);
        chk(v, 8'h17);
        // Core word read by the outside master
        acc(8'h08, 8'hc6, 2'b10);
        acc(8'h89, 8'h00, 2'b01);
        chk(v, 8'h57);
        i_far.slave_read(v);
        chk(v, 8'hc6);
        acc(8'h89, 8'h00, 2'b01);
        chk(v, 8'h17);
        acc(8'h8a, 8'h00, 2'b01);
        chk(v, 8'h05);
        // Back to plain I/O
        acc(8'h89, 8'h02, 2'b10);
        chk({5'h00, dirE}, 8'h02);
        chk(ttlD, 1'b0);
        print_verdict;
    end
endmodule
